// File: verilog/pmspi_pkg.sv
// pmspi_pkg: constants and types of the serial frame handler of the power monitor.
// assumes: shared by the frame handler and by the bench that drives it.
package pmspi_pkg;

    // =========================================================================
    // frame layout
    localparam int          ADDR_W      = 7;     // register address field
    localparam int          DATA_W      = 32;    // data and response fields
    localparam int          FRAME_W     = ADDR_W + 1 + DATA_W;
    localparam logic [5:0]  FRAME_BITS  = 6'h28; // 40 bit clocks per frame
    localparam logic [5:0]  RESP_LAST   = 6'h1f; // last falling edge that shifts the response
    localparam int          DIR_POS     = DATA_W;          // direction bit inside the frame
    localparam int          ADDR_LSB    = DATA_W + 1;      // address lsb inside the frame
    localparam logic        DIR_READ    = 1'b1;  // direction bit value meaning read

    // =========================================================================
    // reset values
    localparam logic [31:0] RESP_RESET  = 32'h0000_0000;
    localparam logic [39:0] FRAME_RESET = 40'h00_0000_0000;

    // =========================================================================
    // link rate
    localparam int          SPI_MAX_HZ  = 10_000_000;
    localparam int          CLK_HZ      = 250_000_000;
    localparam int          SYNC_LAT    = 4;     // cycles from pin edge to shifted output
    // half bit period at the top link rate, in system clocks, rounded down
    localparam int          SCK_HALF_CYC = CLK_HZ / (2 * SPI_MAX_HZ);

    // =========================================================================
    // frame states, gray along idle -> shift -> capture
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SHIFT   = 2'b01,
        ST_CAPTURE = 2'b11
    } pmspi_state_t;

endpackage : pmspi_pkg

// File: verilog/pmspi_frame.sv
// pmspi_frame: serial slave frame handler; turns each frame of 40 bits or more into one register command.
// assumes: register bank on I_CLOCK answers I_RD_DATA combinationally from O_CMD_ADDR;
// link pins are asynchronous and sampled here; link mode 0 (sample rising, shift falling).
//
// How it works
// - link is sampled by the fast clock; margin holds up to ten megahertz bit rate.
// - only the serial slave protocol exists here; no run-time protocol switch.
// - data output is driven from a flop at all times, also with select high.
// - the bit after the address: one means read, zero means write.
// - every frame shifts out a thirty-two bit response, msb first.
// - response carries the result of the last accepted frame's command.
// - write stores the 32-bit data field; read passes it to O_CMD_WDATA too.
`timescale 1ns/1ps
module pmspi_frame (
    input  wire logic                        I_CLOCK,
    input  wire logic                        I_RESETN,
    input  wire logic                        I_CE,
    input  wire logic                        I_SCK,
    input  wire logic                        I_CS_N,
    input  wire logic                        I_MOSI,
    input  wire logic [pmspi_pkg::DATA_W-1:0] I_RD_DATA,
    output logic                             O_MISO,
    output logic                             O_CMD_VALID,
    output logic                             O_CMD_READ,
    output logic      [pmspi_pkg::ADDR_W-1:0] O_CMD_ADDR,
    output logic      [pmspi_pkg::DATA_W-1:0] O_CMD_WDATA
);
    import pmspi_pkg::*;

    // =========================================================================
    // pin synchronisers
    logic [2:0]         meta_reg;      // first stage, read only by sync_reg
    logic [2:0]         sync_reg;      // {sck, cs_n, mosi}
    logic [1:0]         prev_reg;      // delayed {sck, cs_n} for edge detection
    logic [2:0]         meta_next;
    logic [2:0]         sync_next;
    logic [1:0]         prev_next;
    logic               sck_rise;
    logic               sck_fall;
    logic               cs_fall;
    logic               cs_high;
    logic               mosi_s;

    // two flops per pin; a 10 MHz link leaves 12 clocks per half bit for SYNC_LAT of 4
    always_comb begin
        meta_next = {I_SCK, I_CS_N, I_MOSI};
        sync_next = meta_reg;
        prev_next = sync_reg[2:1];
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            meta_reg <= 3'h2;
            sync_reg <= 3'h2;
            prev_reg <= 2'h1;
        end else if (I_CE) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // edges seen only from the second stage onward
    always_comb begin
        sck_rise = sync_reg[2] & ~prev_reg[1];
        sck_fall = ~sync_reg[2] & prev_reg[1];
        cs_fall  = ~sync_reg[1] & prev_reg[0];
        cs_high  = sync_reg[1];
        mosi_s   = sync_reg[0];
    end

    // =========================================================================
    // frame engine
    pmspi_state_t       state_reg;
    pmspi_state_t       state_next;
    logic [5:0]         cnt_reg;       // bits taken in this frame
    logic [5:0]         cnt_next;
    logic [FRAME_W-1:0] sin_reg;       // address, direction, data as received
    logic [FRAME_W-1:0] sin_next;
    logic [DATA_W-1:0]  sout_reg;      // response being shifted out
    logic [DATA_W-1:0]  sout_next;
    logic [DATA_W-1:0]  resp_reg;      // result of the last command, sent next frame
    logic [DATA_W-1:0]  resp_next;
    logic               miso_reg;
    logic               miso_next;
    logic               valid_reg;
    logic               valid_next;
    logic               read_reg;
    logic               read_next;
    logic [ADDR_W-1:0]  addr_reg;
    logic [ADDR_W-1:0]  addr_next;
    logic [DATA_W-1:0]  wdata_reg;
    logic [DATA_W-1:0]  wdata_next;

    // only serial slave framing is built; the protocol choice is fixed at build time
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sin_next   = sin_reg;
        sout_next  = sout_reg;
        resp_next  = resp_reg;
        miso_next  = miso_reg;
        valid_next = 1'b0;
        read_next  = read_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (cs_fall) begin
                    // present the msb of the last result before the first rising edge
                    state_next = ST_SHIFT;
                    cnt_next   = 6'h00;
                    sout_next  = resp_reg;
                    miso_next  = resp_reg[DATA_W-1];
                end
            end
            ST_SHIFT: begin
                if (cs_high) begin
                    // a short frame is dropped; nothing reaches the bank; a long one is taken with its first 40 bits
                    if (cnt_reg == FRAME_BITS) begin
                        state_next = ST_CAPTURE;
                        valid_next = 1'b1;
                        addr_next  = sin_reg[FRAME_W-1:ADDR_LSB];
                        read_next  = (sin_reg[DIR_POS] == DIR_READ);
                        wdata_next = sin_reg[DATA_W-1:0];
                    end else begin
                        state_next = ST_IDLE;
                    end
                end else begin
                    if (sck_rise && cnt_reg < FRAME_BITS) begin
                        sin_next = {sin_reg[FRAME_W-2:0], mosi_s};
                        cnt_next = cnt_reg + 6'h01;
                    end
                    if (sck_fall && cnt_reg != 6'h00 && cnt_reg <= RESP_LAST) begin
                        sout_next = {sout_reg[DATA_W-2:0], 1'b0};
                        miso_next = sout_reg[DATA_W-2];
                    end
                end
            end
            ST_CAPTURE: begin
                // bank answers from O_CMD_ADDR in this cycle; a write echoes its data
                state_next = ST_IDLE;
                resp_next  = read_reg ? I_RD_DATA : wdata_reg;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 6'h00;
            sin_reg   <= FRAME_RESET;
            sout_reg  <= RESP_RESET;
            resp_reg  <= RESP_RESET;
            miso_reg  <= 1'b0;
            valid_reg <= 1'b0;
            read_reg  <= 1'b0;
            addr_reg  <= 7'h00;
            wdata_reg <= RESP_RESET;
        end else if (I_CE) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            sin_reg   <= sin_next;
            sout_reg  <= sout_next;
            resp_reg  <= resp_next;
            miso_reg  <= miso_next;
            valid_reg <= valid_next;
            read_reg  <= read_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
        end
    end

    // outputs straight from flops; data output has no enable, so it is never released
    assign O_MISO      = miso_reg;
    assign O_CMD_VALID = valid_reg;
    assign O_CMD_READ  = read_reg;
    assign O_CMD_ADDR  = addr_reg;
    assign O_CMD_WDATA = wdata_reg;

    // =========================================================================
    // checks, valid while I_CE stays high
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN || !I_CE);

    property p_cmd_count;
        $rose(valid_reg) |-> $past(cnt_reg) == FRAME_BITS && state_reg == ST_CAPTURE;
    endproperty
    a_cmd_count: assert property (p_cmd_count) else $error("command without 40 bits");

    property p_cmd_pulse;
        valid_reg |=> !valid_reg ##1 state_reg == ST_IDLE;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");

    property p_dir_decode;
        valid_reg |-> read_reg == (sin_reg[DIR_POS] == DIR_READ);
    endproperty
    a_dir_decode: assert property (p_dir_decode) else $error("direction bit misdecoded");

    property p_wdata;
        valid_reg |-> wdata_reg == sin_reg[DATA_W-1:0] && addr_reg == sin_reg[FRAME_W-1:ADDR_LSB];
    endproperty
    a_wdata: assert property (p_wdata) else $error("write fields misplaced");

    property p_read_result;
        valid_reg && read_reg |=> resp_reg == $past(I_RD_DATA);
    endproperty
    a_read_result: assert property (p_read_result) else $error("read result not kept");

    property p_first_bit;
        state_reg == ST_IDLE && cs_fall |=> miso_reg == $past(resp_reg[DATA_W-1]) && sout_reg == $past(resp_reg);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first response bit wrong");

    property p_shift_bit;
        state_reg == ST_SHIFT && !cs_high && sck_fall && cnt_reg != 6'h00 && cnt_reg <= RESP_LAST
            |=> miso_reg == $past(sout_reg[DATA_W-2]);
    endproperty
    a_shift_bit: assert property (p_shift_bit) else $error("response bit order wrong");

    property p_cnt_bound;
        cnt_reg <= FRAME_BITS;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("bit count overran frame");

    property p_reset_resp;
        // own disable: the default one would switch this check off for the whole reset
        @(posedge I_CLOCK) disable iff (1'b0) !I_RESETN |=> resp_reg == RESP_RESET && !valid_reg && !miso_reg;
    endproperty
    a_reset_resp: assert property (p_reset_resp) else $error("reset state wrong");

    property p_cov_read;
        valid_reg && read_reg;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_write;
        valid_reg && !read_reg;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_abort;
        state_reg == ST_SHIFT && cs_high && cnt_reg != FRAME_BITS;
    endproperty
    c_cov_abort: cover property (p_cov_abort);

endmodule : pmspi_frame

// File: testbench/pmspi_master.sv
// pmspi_master: behavioural link master for the serial frame handler.
// assumes: mode 0, link clock made here by delays, idle low between frames.
`timescale 1ns/1ps
module pmspi_master (
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    // =========================================================================
    // link timing
    // half period of six system clocks, so the sampler always sees each level
    localparam realtime HALF = 24.0;

    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // one frame of nbits, msb first; resp collects the first 32 samples
    task automatic frame(input logic [39:0] word, input int nbits, output logic [31:0] resp);
        resp   = 32'h0;
        o_cs_n = 1'b0;
        o_mosi = word[39];
        #(HALF);
        for (int i = 0; i < nbits; i++) begin
            o_sck = 1'b1;
            if (i < 32) resp = {resp[30:0], i_miso};
            #(HALF);
            o_sck = 1'b0;
            if (i < 39) o_mosi = word[38-i];
            #(HALF);
        end
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // released line shows the inverse so no stale value passes by luck
        #(2*HALF);
    endtask : frame
endmodule : pmspi_master

// File: testbench/power_monitor_spi_frame_tb.sv
// power_monitor_spi_frame_tb: self-checking bench of the serial frame handler.
// assumes: a random table stands for the register bank, read combinationally.
`timescale 1ns/1ps
module power_monitor_spi_frame_tb;
    import pmspi_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              ce = 1'b1;
    logic              sck, cs_n, mosi, miso, cmd_valid, cmd_read;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_wdata, rd_data, resp, prev;
    logic [DATA_W-1:0] bank [128];
    logic [39:0]       cmd_q [$]; // expected commands
    logic [32:0]       resp_q [$]; // {check, word} expected on the link
    logic              have_prev = 1'b0;
    logic              resp_vld = 1'b0;
    int                err_count = 0;
    int                checks = 0;

    always #2 clk = ~clk;
    assign rd_data = bank[cmd_addr];

    // the only slave on this link
    pmspi_master m_u (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
    pmspi_frame dut_u (.I_CLOCK(clk), .I_RESETN(rst_n), .I_CE(ce), .I_SCK(sck), .I_CS_N(cs_n),
        .I_MOSI(mosi), .I_RD_DATA(rd_data), .O_MISO(miso), .O_CMD_VALID(cmd_valid),
        .O_CMD_READ(cmd_read), .O_CMD_ADDR(cmd_addr), .O_CMD_WDATA(cmd_wdata));

    // =========================================================================
    // checking and closing
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // command port watcher: sampled before the edge's own updates land
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            if (cmd_q.size() == 0) check(40'h1, 40'h0);
            else check({cmd_addr, cmd_read, cmd_wdata}, cmd_q.pop_front());
        end else if (rst_n && cmd_valid !== 1'b0) begin
            check({39'h0, cmd_valid}, 40'h0);
        end
    end

    // link response watcher; first word after reset is discarded
    always @(posedge resp_vld) begin
        if (resp_q[0][32]) check({8'h0, resp}, {8'h0, resp_q[0][31:0]});
        void'(resp_q.pop_front());
    end

    // =========================================================================
    // stimulus
    task automatic do_reset();
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        have_prev = 1'b0;
        check({38'h0, miso, cmd_valid}, 40'h0);
        check({cmd_addr, cmd_read, cmd_wdata}, 40'h0);
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic send(input logic [6:0] a, input logic rd, input logic [31:0] d, input int nbits);
        logic [31:0] r;
        // pins move one nanosecond after a clock edge, never on it
        @(posedge clk);
        #1;
        if (nbits == 40) cmd_q.push_back({a, rd, d});
        resp_q.push_back({have_prev, prev});
        m_u.frame({a, rd, d}, nbits, r);
        resp = r;
        resp_vld = 1'b1;
        #1 resp_vld = 1'b0;
        check({39'h0, miso}, {39'h0, r[0]});
        if (nbits == 40) begin
            have_prev = 1'b1;
            prev = (rd == DIR_READ) ? bank[a] : d;
        end
    endtask : send

    initial begin
        void'($urandom(26));
        foreach (bank[i]) bank[i] = $urandom();
        prev = 32'h0;
        do_reset();
        $display("test reset done");
        // field boundaries, both directions, back to back
        send(7'h00, 1'b0, 32'hffff_ffff, 40);
        send(7'h7f, 1'b1, 32'h0000_0000, 40);
        send(7'h7f, 1'b0, 32'h8000_0001, 40);
        send(7'h00, 1'b1, 32'h5a5a_a5a5, 40);
        $display("test corners done");
        for (int i = 0; i < 12; i++) send(7'($urandom()), 1'($urandom()), $urandom(), 40);
        $display("test random done");
        // short frame is dropped and leaves the pending response alone
        send(7'h15, 1'b0, 32'h1234_5678, 39);
        send(7'h16, 1'b1, 32'h0, 40);
        $display("test abort done");
        // frozen clock enable: a whole frame on the pins leaves outputs and pending response alone
        @(posedge clk);
        #1 ce = 1'b0;
        m_u.frame({7'h33, 1'b0, 32'hdead_beef}, 40, resp);
        check({8'h0, resp}, {8'h0, {32{miso}}});
        check({cmd_addr, cmd_read, cmd_wdata}, {7'h16, 1'b1, 32'h0});
        @(posedge clk);
        #1 ce = 1'b1;
        send(7'h17, 1'b0, 32'h0, 40);
        $display("test enable done");
        // second reset mid-run: first response again without meaning
        do_reset();
        send(7'h2a, 1'b0, $urandom(), 40);
        send(7'h2a, 1'b1, $urandom(), 40);
        $display("test rereset done");
        for (int i = 0; i < 50 && cmd_q.size() != 0; i++) @(posedge clk);
        if (cmd_q.size() != 0) err_count++;
        report_and_stop();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule : power_monitor_spi_frame_tb
